// >>> rtl/reset_cause_pkg.sv
// Constants and types for the reset cause and status register block
package reset_cause_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // Byte addresses of the registers
    localparam logic [11:0] OFS_CAUSE = 12'h000;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFS_LEVELS = 12'h00C;

    // Field positions in the cause register
    localparam int BIT_POR = 0;
    localparam int BIT_BOR = 1;
    localparam int BIT_IDLE = 2;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int BIT_WATCHDOG_SOFT_ENABLE = 5;
    localparam int BIT_SWR = 6;
    localparam int BIT_PIN_RESET_FLAG = 7;
    localparam int BIT_REGULATOR_SLEEP_STANDBY = 8;
    localparam int BIT_CM = 9;
    localparam int BIT_FLASH_REGULATOR_STANDBY = 11;
    localparam int BIT_ILLEGAL_ACCESS_FLAG = 14;
    localparam int BIT_TRAP_CONFLICT_FLAG = 15;

    localparam logic [15:0] CAUSE_RESET = 16'h0003;
    localparam logic [15:0] CAUSE_WRITABLE = 16'hCBFF;
    localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

    // Requests from the reset sources and power-state logic, asynchronous levels
    typedef struct packed {
        logic trapConflict;
        logic illegalAccess;
        logic configMismatch;
        logic pinReset;
        logic instructionReset;
        logic watchdogTimeout;
        logic sleepWake;
        logic idleWake;
        logic brownout;
    } resetSources_t;

    localparam int SRC_W = $bits(resetSources_t);

    typedef enum {
        SEL_CAUSE,
        SEL_IRQ_STATUS,
        SEL_IRQ_MASK,
        SEL_LEVELS,
        SEL_NONE
    } regSel_t;

endpackage

// >>> rtl/edge_sync.sv
// Two-flop synchroniser with registered rising-edge detect
`timescale 1ns/1ps
module edge_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] delayed;
        logic [WIDTH-1:0] rise;
    } syncState_t;

    syncState_t s_q;
    syncState_t s_d;

    // Meta is read only by the stable stage
    always_comb begin
        s_d = s_q;
        s_d.meta = asyncIn;
        s_d.stable = s_q.meta;
        s_d.delayed = s_q.stable;
        s_d.rise = s_q.stable & ~s_q.delayed;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.stable;
    assign rise = s_q.rise;

endmodule

// >>> rtl/reset_cause_register.sv
// Reset cause and status register with APB access and cause-event interrupt
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module reset_cause_register (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [reset_cause_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [reset_cause_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [reset_cause_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire reset_cause_pkg::resetSources_t sourceRequest,
    input wire logic watchdogFuseEnable,
    output logic watchdogEnable,
    output logic flashRegulatorStandby,
    output logic regulatorSleepStandby,
    output logic irq
);

    typedef struct packed {
        logic [reset_cause_pkg::REG_W-1:0] cause;
        logic [reset_cause_pkg::REG_W-1:0] irqStatus;
        logic [reset_cause_pkg::REG_W-1:0] irqMask;
        logic [reset_cause_pkg::DATA_W-1:0] rdata;
        logic wdtEnable;
        logic irq;
    } regState_t;

    // Cause flags at power-on; pending bits and enables start clear
    localparam regState_t STATE_RESET = '{
        cause: reset_cause_pkg::CAUSE_RESET,
        irqStatus: '0,
        irqMask: reset_cause_pkg::IRQ_MASK_RESET,
        rdata: '0,
        wdtEnable: 1'b0,
        irq: 1'b0
    };

    localparam int SYNC_W = reset_cause_pkg::SRC_W + 1;

    regState_t s_q;
    regState_t s_d;

    logic [SYNC_W-1:0] syncLevel;
    logic [SYNC_W-1:0] syncRise;
    reset_cause_pkg::resetSources_t srcLevel;
    reset_cause_pkg::resetSources_t srcRise;
    logic fuseLevel;

    // Register map, one 16-bit register per aligned word, upper half reads zero except the fuse bit of levels:
    //   cause   - sticky reset cause flags, watchdog soft enable, regulator standby bits
    //   status  - one pending bit per cause event, cleared by writing a one
    //   mask    - enables a pending bit onto the interrupt line
    //   levels  - synchronised source levels in the cause layout, fuse above them
    // Cause layout: 0 power-on, 1 brown-out, 2 idle, 3 sleep, 4 watchdog time-out,
    //   5 soft watchdog enable, 6 instruction reset, 7 pin reset, 8 regulator sleep
    //   standby, 9 config mismatch, 11 flash regulator standby, 14 illegal access,
    //   15 trap conflict; 10, 12 and 13 are reserved and read zero.
    // Offsets are byte addresses; misaligned or unknown ones answer with an error.
    // Address decode, shared by the read path and the write path
    function automatic reset_cause_pkg::regSel_t decodeAddr(
        input logic [reset_cause_pkg::ADDR_W-1:0] addr
    );
        reset_cause_pkg::regSel_t sel;
        case (addr)
            reset_cause_pkg::OFS_CAUSE: begin
                sel = reset_cause_pkg::SEL_CAUSE;
            end
            reset_cause_pkg::OFS_IRQ_STATUS: begin
                sel = reset_cause_pkg::SEL_IRQ_STATUS;
            end
            reset_cause_pkg::OFS_IRQ_MASK: begin
                sel = reset_cause_pkg::SEL_IRQ_MASK;
            end
            reset_cause_pkg::OFS_LEVELS: begin
                sel = reset_cause_pkg::SEL_LEVELS;
            end
            default: begin
                sel = reset_cause_pkg::SEL_NONE;
            end
        endcase
        return sel;
    endfunction

    // Places each source at its flag position in the 16-bit layout
    function automatic logic [reset_cause_pkg::REG_W-1:0] toFlags(
        input reset_cause_pkg::resetSources_t src
    );
        logic [reset_cause_pkg::REG_W-1:0] f;
        f = '0;
        f[reset_cause_pkg::BIT_TRAP_CONFLICT_FLAG] = src.trapConflict;
        f[reset_cause_pkg::BIT_ILLEGAL_ACCESS_FLAG] = src.illegalAccess;
        f[reset_cause_pkg::BIT_CM] = src.configMismatch;
        f[reset_cause_pkg::BIT_PIN_RESET_FLAG] = src.pinReset;
        f[reset_cause_pkg::BIT_SWR] = src.instructionReset;
        f[reset_cause_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = src.watchdogTimeout;
        f[reset_cause_pkg::BIT_SLEEP] = src.sleepWake;
        f[reset_cause_pkg::BIT_IDLE] = src.idleWake;
        f[reset_cause_pkg::BIT_BOR] = src.brownout;
        return f;
    endfunction

    // Byte enables of the low half word, the only lanes that hold data
    function automatic logic [reset_cause_pkg::REG_W-1:0] laneMask(
        input logic [3:0] strb
    );
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Read-modify-write of the enabled bits; bits outside the mask keep their value
    function automatic logic [reset_cause_pkg::REG_W-1:0] mergeBits(
        input logic [reset_cause_pkg::REG_W-1:0] oldBits,
        input logic [reset_cause_pkg::REG_W-1:0] newBits,
        input logic [reset_cause_pkg::REG_W-1:0] mask
    );
        logic [reset_cause_pkg::REG_W-1:0] merged;
        merged = (oldBits & ~mask) | (newBits & mask);
        return merged;
    endfunction

    // Write-one-to-clear of the enabled bits; written zeros leave bits alone
    function automatic logic [reset_cause_pkg::REG_W-1:0] clearOnes(
        input logic [reset_cause_pkg::REG_W-1:0] oldBits,
        input logic [reset_cause_pkg::REG_W-1:0] newBits,
        input logic [reset_cause_pkg::REG_W-1:0] mask
    );
        logic [reset_cause_pkg::REG_W-1:0] cleared;
        cleared = oldBits & ~(newBits & mask);
        return cleared;
    endfunction

    // One register hit by a write in the access phase
    function automatic logic hitReg(
        input logic write,
        input reset_cause_pkg::regSel_t sel,
        input reset_cause_pkg::regSel_t target
    );
        logic hit;
        hit = write && (sel == target);
        return hit;
    endfunction

    // Reserved cause bits never take a write, whatever the strobes say
    function automatic logic [reset_cause_pkg::REG_W-1:0] causeLanes(
        input logic [reset_cause_pkg::REG_W-1:0] lanes
    );
        return lanes & reset_cause_pkg::CAUSE_WRITABLE;
    endfunction

    // Level request while any pending flag is also enabled
    function automatic logic irqLevel(
        input logic [reset_cause_pkg::REG_W-1:0] status,
        input logic [reset_cause_pkg::REG_W-1:0] mask
    );
        logic level;
        level = |(status & mask);
        return level;
    endfunction

    // An unprogrammed fuse keeps the watchdog running; software cannot stop it then
    function automatic logic watchdogOn(
        input logic fuse,
        input logic [reset_cause_pkg::REG_W-1:0] cause
    );
        logic on;
        on = fuse | cause[reset_cause_pkg::BIT_WATCHDOG_SOFT_ENABLE];
        return on;
    endfunction

    // Read word of one register; unmapped and unused bits read zero
    function automatic logic [reset_cause_pkg::DATA_W-1:0] readWord(
        input reset_cause_pkg::regSel_t sel,
        input logic [reset_cause_pkg::REG_W-1:0] cause,
        input logic [reset_cause_pkg::REG_W-1:0] status,
        input logic [reset_cause_pkg::REG_W-1:0] mask,
        input logic [reset_cause_pkg::REG_W-1:0] levels,
        input logic fuse
    );
        logic [reset_cause_pkg::DATA_W-1:0] word;
        word = '0;
        case (sel)
            reset_cause_pkg::SEL_CAUSE: begin
                word[reset_cause_pkg::REG_W-1:0] = cause;
            end
            reset_cause_pkg::SEL_IRQ_STATUS: begin
                word[reset_cause_pkg::REG_W-1:0] = status;
            end
            reset_cause_pkg::SEL_IRQ_MASK: begin
                word[reset_cause_pkg::REG_W-1:0] = mask;
            end
            reset_cause_pkg::SEL_LEVELS: begin
                word[reset_cause_pkg::REG_W-1:0] = levels;
                word[reset_cause_pkg::REG_W] = fuse;
            end
            default: begin
                word = '0;
            end
        endcase
        return word;
    endfunction

    // Sources and the fuse strap come from other logic or pins, so all are synchronised.
    // A request costs four edges before its flag sets: two to settle, one to find the
    // edge, one to store the flag. Pulses shorter than a clock period may be missed; requests must be held
    // for at least one cycle and must fall for one cycle before they count again.
    edge_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({watchdogFuseEnable, sourceRequest}),
        .level(syncLevel),
        .rise(syncRise)
    );

    assign srcLevel = syncLevel[reset_cause_pkg::SRC_W-1:0];
    assign srcRise = syncRise[reset_cause_pkg::SRC_W-1:0];
    assign fuseLevel = syncLevel[SYNC_W-1];

    // Bus phases and register hits, shared by the state update and the error response
    logic setupRead;
    logic accessPhase;
    logic accessWrite;
    reset_cause_pkg::regSel_t busSel;
    logic hitCause;
    logic hitStatus;
    logic hitMask;

    // Decoded write data and the flag patterns of the synchronised sources
    logic [reset_cause_pkg::REG_W-1:0] byteMask;
    logic [reset_cause_pkg::REG_W-1:0] busData;
    logic [reset_cause_pkg::REG_W-1:0] setFlags;
    logic [reset_cause_pkg::REG_W-1:0] levelFlags;

    assign accessPhase = psel && penable;
    assign setupRead = psel && !penable && !pwrite;
    assign accessWrite = accessPhase && pwrite;
    assign busSel = decodeAddr(paddr);
    assign hitCause = hitReg(
        accessWrite,
        busSel,
        reset_cause_pkg::SEL_CAUSE
    );
    assign hitStatus = hitReg(
        accessWrite,
        busSel,
        reset_cause_pkg::SEL_IRQ_STATUS
    );
    assign hitMask = hitReg(
        accessWrite,
        busSel,
        reset_cause_pkg::SEL_IRQ_MASK
    );
    assign byteMask = laneMask(pstrb);
    assign busData = pwdata[reset_cause_pkg::REG_W-1:0];
    // Only rising edges set flags, so a request held high is recorded once
    assign setFlags = toFlags(srcRise);
    assign levelFlags = toFlags(srcLevel);

    always_comb begin
        s_d = s_q;

        // Software write only stores the value; nothing here reaches a reset
        if (hitCause) begin
            s_d.cause = mergeBits(
                s_q.cause,
                busData,
                causeLanes(byteMask)
            );
        end
        // A source edge in the same cycle as a software clear still leaves its flag set
        s_d.cause = s_d.cause | setFlags;

        if (hitStatus) begin
            s_d.irqStatus = clearOnes(
                s_q.irqStatus,
                busData,
                byteMask
            );
        end
        s_d.irqStatus = s_d.irqStatus | setFlags;

        if (hitMask) begin
            s_d.irqMask = mergeBits(
                s_q.irqMask,
                busData,
                byteMask
            );
        end

        s_d.irq = irqLevel(
            s_d.irqStatus,
            s_d.irqMask
        );

        // Fuse forces the watchdog on whatever the soft enable holds
        s_d.wdtEnable = watchdogOn(
            fuseLevel,
            s_d.cause
        );

        // Read data is captured in the setup cycle so it leaves a flop in the access cycle
        if (setupRead) begin
            s_d.rdata = readWord(
                busSel,
                s_q.cause,
                s_q.irqStatus,
                s_q.irqMask,
                levelFlags,
                fuseLevel
            );
        end
    end

    // Power-on reset loads the cause register with only the power-on and brown-out flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero wait states; an unmapped address answers with an error and changes nothing
    assign pready = 1'b1;
    assign pslverr = accessPhase && (busSel == reset_cause_pkg::SEL_NONE);
    assign prdata = s_q.rdata;

    // Standby bits are plain stored values: 1 keeps that regulator active in sleep
    assign watchdogEnable = s_q.wdtEnable;
    assign flashRegulatorStandby = s_q.cause[reset_cause_pkg::BIT_FLASH_REGULATOR_STANDBY];
    assign regulatorSleepStandby = s_q.cause[reset_cause_pkg::BIT_REGULATOR_SLEEP_STANDBY];
    assign irq = s_q.irq;

endmodule

// >>> verification/reset_cause_properties.sv
// Port-level properties of the reset cause register
`timescale 1ns/1ps
module reset_cause_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic watchdogFuseEnable,
    input wire logic watchdogEnable,
    input wire logic flashRegulatorStandby,
    input wire logic regulatorSleepStandby
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc;
    logic bad;
    logic wrCause;
    assign acc = psel && penable;
    assign bad = paddr > 12'h00C || paddr[1:0] != 2'h0;
    assign wrCause = acc && pwrite && paddr == 12'h000;
    ready_high_a: assert property (pready) else $error("pready low");
    bad_err_a: assert property (acc && bad |-> pslverr) else $error("no error");
    good_ok_a: assert property (acc && !bad |-> !pslverr) else $error("false error");
    idle_err_a: assert property (!acc |-> !pslverr) else $error("idle error");
    bad_read_a: assert property (acc && bad && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read data");
    cause_rsvd_a: assert property (acc && !pwrite && paddr == 12'h000
        |-> (prdata & 32'hFFFF3400) == 32'h0) else $error("reserved bits set");
    fuse_wdog_a: assert property (watchdogFuseEnable [*5] |-> watchdogEnable)
        else $error("fuse ignored");
    soft_wdog_a: assert property (wrCause && pstrb[0] && pwdata[5] |-> ##2 watchdogEnable)
        else $error("soft enable ignored");
    vreg_copy_a: assert property (wrCause && pstrb[1] |-> ##2
        regulatorSleepStandby == $past(pwdata[8], 2)
        && flashRegulatorStandby == $past(pwdata[11], 2)) else $error("standby copy");
endmodule

// >>> verification/test_reset_cause_register.sv
// Self-checking bench for the reset cause register
`timescale 1ns/1ps
module test_reset_cause_register;
    logic clk = 0;
    logic rst_n = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic watchdogFuseEnable = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h3;
    logic [reset_cause_pkg::SRC_W-1:0] sourceRequest = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, watchdogEnable, flashRegulatorStandby, regulatorSleepStandby, irq, err;
    int errors = 0;
    int cmp_count = 0;
    int pos[9] = '{1, 2, 3, 4, 6, 7, 9, 14, 15};
    always #10 clk = ~clk;
    reset_cause_register dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .sourceRequest, .watchdogFuseEnable, .watchdogEnable,
        .flashRegulatorStandby, .regulatorSleepStandby, .irq);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Zero wait states are promised, but the wait is still bounded, never assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 16'h0000);
        chk(n, e, rd);
    endtask
    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdchk("cause", 12'h000, 32'h0003);
        rdchk("status", 12'h004, 32'h0);
        rdchk("mask", 12'h008, 32'h0);
    endtask
    task automatic t_soft;
        apb(1'b1, 12'h000, 16'hFFFF);
        rdchk("cause", 12'h000, 32'hCBFF);
        rdchk("status", 12'h004, 32'h0);
        chk("wdog", 1, watchdogEnable);
        chk("vreg", 3, {flashRegulatorStandby, regulatorSleepStandby});
        apb(1'b1, 12'h000, 16'h0000);
        rdchk("cause", 12'h000, 32'h0);
        apb(1'b0, 12'h010, 16'h0000);
        chk("bad data", 0, rd);
        chk("bad err", 1, err);
    endtask
    task automatic t_sources;
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 12'h008, (i == 5) ? 16'h0000 : 16'hFFFF);
            sourceRequest[i] <= 1'b1;
            repeat (6) @(posedge clk);
            chk("irq", (i == 5) ? 0 : 1, irq);
            rdchk("levels", 12'h00C, 32'h1 << pos[i]);
            sourceRequest[i] <= 1'b0;
            rdchk("cause", 12'h000, 32'h1 << pos[i]);
            rdchk("status", 12'h004, 32'h1 << pos[i]);
            apb(1'b1, 12'h004, 16'hFFFF);
            apb(1'b1, 12'h000, 16'h0000);
        end
        chk("irq", 0, irq);
    endtask
    task automatic t_fuse;
        watchdogFuseEnable <= 1'b1;
        repeat (5) @(posedge clk);
        chk("wdog", 1, watchdogEnable);
        rdchk("levels", 12'h00C, 32'h0001_0000);
        watchdogFuseEnable <= 1'b0;
        repeat (5) @(posedge clk);
        chk("wdog", 0, watchdogEnable);
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        apb(1'b1, 12'h000, 16'hFFFF);
        t_reset();
        t_soft();
        t_sources();
        t_fuse();
        final_report();
    end
    initial begin
        #100us;
        errors++;
        final_report();
    end
endmodule
bind reset_cause_register reset_cause_properties chk (.clk, .rst_n, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .watchdogFuseEnable, .watchdogEnable,
    .flashRegulatorStandby, .regulatorSleepStandby);
